// ===== rtl/flash_por_regs.vh
/*
 * Constants for the flash power-on/reset front end: clock rate, start-up
 * waits and reset values.
 * Assumes it is included by its bare name from the rtl/ design files.
 */
`ifndef FLASH_POR_REGS_VH
`define FLASH_POR_REGS_VH

// ==========================================================================
// clock
// ==========================================================================
`define FPOR_CLK_MHZ            200

// ==========================================================================
// start-up waits
// ==========================================================================
// host side wait, kept for reference by the bench
`define FPOR_VCC_TO_SELECT_US   70
`define FPOR_VCC_TO_SELECT_CYC  (`FPOR_VCC_TO_SELECT_US * `FPOR_CLK_MHZ)
// device side delay before a first program or erase, longest time
`define FPOR_PE_DELAY_MS        3
`define FPOR_PE_DELAY_CYC       (`FPOR_PE_DELAY_MS * 1000 * `FPOR_CLK_MHZ)
`define FPOR_PE_CNT_W           20

// ==========================================================================
// reset values and fields
// ==========================================================================
`define FPOR_MODE3_RESET        1'b1
`define FPOR_BYTE_W             8
`define FPOR_BIT_CNT_W          3
`define FPOR_BYTE_MSB           7

`endif

// ===== rtl/flash_power_on_reset_state.v
/*
 * Power-on/reset front end of a serial flash slave interface: mode
 * selection on chip select falling edge, opcode capture, serial output
 * drive control and the program/erase start-up delay.
 * Assumes rst is the internal power-on reset (synchronous, active high),
 * the SPI pins are asynchronous to sys_clk and much slower than it, and a
 * command core on sys_clk consumes the opcode and supplies output bytes.
 */
// Function
// - after power-up or reset the interface runs in SPI mode 3 until a later select edge.
// - after power-up or reset the serial output is released and only driven for output data.
// - an instruction starts only after a high-to-low chip select edge, even the first one.
// - each select falling edge samples the idle clock level, high gives mode 3, low mode 0.
// - while power-on reset is active every operation is off and serial commands are ignored.
// - after power-on reset releases the device enters standby once select is seen high, ready for instructions.
// - a first program or erase waits for an internal delay of at most 3 ms.
`include "flash_por_regs.vh"

module flash_power_on_reset_state #(
    parameter [`FPOR_PE_CNT_W-1:0] PE_DELAY_CYCLES = `FPOR_PE_DELAY_CYC
) (
    input  wire                      sys_clk,
    input  wire                      rst,
    input  wire                      spi_clk_pin,
    input  wire                      chip_select_n_pin,
    input  wire                      serial_in_pin,
    output wire                      serial_output_o,
    output wire                      serial_output_oe,
    input  wire                      output_request,
    input  wire [`FPOR_BYTE_W-1:0]   tx_byte,
    output wire                      tx_load,
    output wire [`FPOR_BYTE_W-1:0]   opcode,
    output wire                      opcode_valid,
    output wire [`FPOR_BYTE_W-1:0]   rx_byte,
    output wire                      rx_valid,
    output wire                      spi_mode3,
    output wire                      selected,
    output wire                      standby,
    output wire                      program_erase_ready
);

    // ======================================================================
    // states
    // ======================================================================
    localparam [1:0] ST_POR     = 2'b00;
    localparam [1:0] ST_STANDBY = 2'b01;
    localparam [1:0] ST_OPCODE  = 2'b10;
    localparam [1:0] ST_DATA    = 2'b11;

    // ======================================================================
    // pin synchronisers
    // ======================================================================
    wire sck_s;
    wire cs_n_s;
    wire si_s;

    pin_sync2 u_sync_sck (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .reset_level (1'b1),
        .pin_in      (spi_clk_pin),
        .pin_sync    (sck_s)
    );

    // select synchroniser resets low: the reset wait only ends on a select
    // level really seen high, never on the flops' own reset value
    pin_sync2 u_sync_cs (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .reset_level (1'b0),
        .pin_in      (chip_select_n_pin),
        .pin_sync    (cs_n_s)
    );

    pin_sync2 u_sync_si (
        .sys_clk     (sys_clk),
        .rst         (rst),
        .reset_level (1'b1),
        .pin_in      (serial_in_pin),
        .pin_sync    (si_s)
    );

    // ======================================================================
    // edge detection
    // ======================================================================
    reg sck_prev_q;
    reg cs_n_prev_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            sck_prev_q  <= 1'b1;
            cs_n_prev_q <= 1'b1;
        end else begin
            sck_prev_q  <= sck_s;
            cs_n_prev_q <= cs_n_s;
        end
    end

    wire sck_rise = sck_s & ~sck_prev_q;
    wire sck_fall = ~sck_s & sck_prev_q;
    // edges seen while still in the reset wait are ignored, so a select
    // held low through reset never counts as a falling edge
    wire cs_fall  = ~cs_n_s & cs_n_prev_q;
    wire cs_rise  = cs_n_s & ~cs_n_prev_q;

    // ======================================================================
    // state machine
    // ======================================================================
    reg [1:0]                  state_q;
    reg [1:0]                  state_d;
    reg                        mode3_q;
    reg [`FPOR_BYTE_W-1:0]     shift_in_q;
    reg [`FPOR_BIT_CNT_W-1:0]  bit_cnt_q;
    reg [`FPOR_BYTE_W-1:0]     opcode_q;
    reg                        opcode_valid_q;
    reg [`FPOR_BYTE_W-1:0]     rx_byte_q;
    reg                        rx_valid_q;
    reg [`FPOR_BYTE_W-1:0]     shift_out_q;
    reg                        tx_armed_q;
    reg                        tx_first_q;
    reg                        tx_load_q;
    reg                        so_q;
    reg                        so_oe_q;
    reg                        standby_q;
    reg                        selected_q;

    wire byte_done = sck_rise & (bit_cnt_q == `FPOR_BYTE_MSB);

    always @* begin
        state_d = state_q;
        case (state_q)
            // leaves reset only once select is seen high
            ST_POR: begin
                if (cs_n_s)
                    state_d = ST_STANDBY;
            end
            ST_STANDBY: begin
                if (cs_fall)
                    state_d = ST_OPCODE;
            end
            ST_OPCODE: begin
                if (cs_rise)
                    state_d = ST_STANDBY;
                else if (byte_done)
                    state_d = ST_DATA;
            end
            ST_DATA: begin
                if (cs_rise)
                    state_d = ST_STANDBY;
            end
            default: state_d = ST_STANDBY;
        endcase
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            state_q <= ST_POR;
        end else begin
            state_q <= state_d;
        end
    end

    wire active = (state_q == ST_OPCODE) | (state_q == ST_DATA);

    // ======================================================================
    // mode selection
    // ======================================================================
    always @(posedge sys_clk) begin
        if (rst) begin
            mode3_q <= `FPOR_MODE3_RESET;
        end else if ((state_q == ST_STANDBY) && cs_fall) begin
            // clock level seen at the select edge is the idle level
            mode3_q <= sck_s;
        end
    end

    // ======================================================================
    // receive path: both modes sample on the rising clock edge
    // ======================================================================
    always @(posedge sys_clk) begin
        if (rst) begin
            shift_in_q     <= {`FPOR_BYTE_W{1'b0}};
            bit_cnt_q      <= {`FPOR_BIT_CNT_W{1'b0}};
            opcode_q       <= {`FPOR_BYTE_W{1'b0}};
            opcode_valid_q <= 1'b0;
            rx_byte_q      <= {`FPOR_BYTE_W{1'b0}};
            rx_valid_q     <= 1'b0;
        end else begin
            opcode_valid_q <= 1'b0;
            rx_valid_q     <= 1'b0;
            if (!active) begin
                // clocks outside a selected frame are dropped
                bit_cnt_q <= {`FPOR_BIT_CNT_W{1'b0}};
            end else if (sck_rise && !cs_n_s) begin
                shift_in_q <= {shift_in_q[`FPOR_BYTE_MSB-1:0], si_s};
                bit_cnt_q  <= bit_cnt_q + 1'b1;
                if (byte_done && state_q == ST_OPCODE) begin
                    opcode_q       <= {shift_in_q[`FPOR_BYTE_MSB-1:0], si_s};
                    opcode_valid_q <= 1'b1;
                end else if (byte_done) begin
                    rx_byte_q  <= {shift_in_q[`FPOR_BYTE_MSB-1:0], si_s};
                    rx_valid_q <= 1'b1;
                end
            end
        end
    end

    // ======================================================================
    // transmit path: data changes on the falling clock edge
    // ======================================================================
    // the core answers output_request in the cycle after opcode_valid; a
    // byte is loaded at each byte boundary while it keeps asking
    always @(posedge sys_clk) begin
        if (rst) begin
            shift_out_q <= {`FPOR_BYTE_W{1'b0}};
            tx_armed_q  <= 1'b0;
            tx_first_q  <= 1'b0;
            tx_load_q   <= 1'b0;
            so_q        <= 1'b0;
            so_oe_q     <= 1'b0;
        end else begin
            tx_load_q <= 1'b0;
            if (state_q != ST_DATA || cs_rise) begin
                tx_armed_q <= 1'b0;
                tx_first_q <= 1'b0;
                so_oe_q    <= 1'b0;
            end else if (!tx_armed_q) begin
                if (output_request && bit_cnt_q == {`FPOR_BIT_CNT_W{1'b0}}) begin
                    shift_out_q <= tx_byte;
                    tx_armed_q  <= 1'b1;
                    tx_first_q  <= 1'b1;
                    tx_load_q   <= 1'b1;
                end
            end else if (sck_fall) begin
                so_q    <= shift_out_q[`FPOR_BYTE_MSB];
                so_oe_q <= 1'b1;
                if (tx_first_q) begin
                    // first fall after a load also sits at bit count zero;
                    // it shows the loaded byte instead of starting another
                    tx_first_q  <= 1'b0;
                    shift_out_q <= {shift_out_q[`FPOR_BYTE_MSB-1:0], 1'b0};
                end else if (bit_cnt_q == {`FPOR_BIT_CNT_W{1'b0}} && !output_request) begin
                    // request dropped: release the pin at the byte boundary
                    so_oe_q    <= 1'b0;
                    tx_armed_q <= 1'b0;
                end else if (bit_cnt_q == {`FPOR_BIT_CNT_W{1'b0}}) begin
                    so_q        <= tx_byte[`FPOR_BYTE_MSB];
                    shift_out_q <= {tx_byte[`FPOR_BYTE_MSB-1:0], 1'b0};
                    tx_load_q   <= 1'b1;
                end else begin
                    shift_out_q <= {shift_out_q[`FPOR_BYTE_MSB-1:0], 1'b0};
                end
            end
        end
    end

    // ======================================================================
    // status and program/erase start-up delay
    // ======================================================================
    reg [`FPOR_PE_CNT_W-1:0] pe_cnt_q;
    reg                      pe_ready_q;

    always @(posedge sys_clk) begin
        if (rst) begin
            pe_cnt_q   <= {`FPOR_PE_CNT_W{1'b0}};
            pe_ready_q <= 1'b0;
            standby_q  <= 1'b0;
            selected_q <= 1'b0;
        end else begin
            // counts from reset release; longest wait, so no extra margin
            if (!pe_ready_q) begin
                pe_cnt_q <= pe_cnt_q + 1'b1;
                if (pe_cnt_q == PE_DELAY_CYCLES - 1'b1)
                    pe_ready_q <= 1'b1;
            end
            standby_q  <= (state_d == ST_STANDBY);
            selected_q <= (state_d == ST_OPCODE) | (state_d == ST_DATA);
        end
    end

    assign serial_output_o     = so_q;
    assign serial_output_oe    = so_oe_q;
    assign tx_load             = tx_load_q;
    assign opcode              = opcode_q;
    assign opcode_valid        = opcode_valid_q;
    assign rx_byte             = rx_byte_q;
    assign rx_valid            = rx_valid_q;
    assign spi_mode3           = mode3_q;
    assign selected            = selected_q;
    assign standby             = standby_q;
    assign program_erase_ready = pe_ready_q;

endmodule // flash_power_on_reset_state

// ===== rtl/pin_sync2.v
/*
 * Two flip-flop synchroniser for one asynchronous pin level.
 * Assumes the input comes from outside the sys_clk domain; only the second
 * stage is visible outside.
 */
module pin_sync2 (
    input  wire sys_clk,
    input  wire rst,
    input  wire reset_level,
    input  wire pin_in,
    output wire pin_sync
);
    reg meta_q;
    reg sync_q;

    // reset value is a constant per instance (tied at the instance)
    always @(posedge sys_clk) begin
        if (rst) begin
            meta_q <= reset_level;
            sync_q <= reset_level;
        end else begin
            meta_q <= pin_in;
            sync_q <= meta_q;
        end
    end

    assign pin_sync = sync_q;
endmodule // pin_sync2

// ===== tb/flash_por_sva.sv
/* Port assertions for flash_power_on_reset_state.
   Assumes one sys_clk domain and a bind placed in the bench top file. */
module flash_por_sva #(
    parameter int PE_DELAY_CYCLES = 50
) (
    input logic sys_clk,
    input logic rst,
    input logic serial_output_oe,
    input logic output_request,
    input logic tx_load,
    input logic opcode_valid,
    input logic rx_valid,
    input logic spi_mode3,
    input logic selected,
    input logic standby,
    input logic program_erase_ready
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    int cnt_q;

    // ==========================================
    // cycles since reset release, saturating so long runs stay legal
    always @(posedge sys_clk) begin
        if (rst)
            cnt_q <= 0;
        else if (cnt_q < 1000000)
            cnt_q <= cnt_q + 1;
    end

    // ==========================================
    property p_reset_mode; disable iff (1'b0) rst |=> spi_mode3; endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("mode not 3 after reset");
    property p_reset_so; disable iff (1'b0) rst |=> !serial_output_oe && !selected; endproperty
    a_reset_so: assert property (p_reset_so) else $error("output driven in reset");
    property p_reset_quiet;
        disable iff (1'b0) rst |=> !opcode_valid && !rx_valid && !tx_load && !standby;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("activity in reset");
    property p_standby_excl; standby |-> !selected; endproperty
    a_standby_excl: assert property (p_standby_excl) else $error("standby in frame");
    property p_op_in_frame; opcode_valid |-> selected; endproperty
    a_op_in_frame: assert property (p_op_in_frame) else $error("opcode outside frame");
    property p_mode_hold; selected && $past(selected) |-> $stable(spi_mode3); endproperty
    a_mode_hold: assert property (p_mode_hold) else $error("mode changed in frame");
    property p_tx_req; tx_load |-> output_request || $past(output_request); endproperty
    a_tx_req: assert property (p_tx_req) else $error("load without request");
    property p_pe_early; program_erase_ready |-> cnt_q >= PE_DELAY_CYCLES - 2; endproperty
    a_pe_early: assert property (p_pe_early) else $error("start-up delay too short");
    property p_pe_late; cnt_q == PE_DELAY_CYCLES + 5 |-> program_erase_ready; endproperty
    a_pe_late: assert property (p_pe_late) else $error("start-up delay too long");
endmodule // flash_por_sva

// ===== tb/flash_power_on_reset_state_tb_top.sv
/* Self-checking bench for flash_power_on_reset_state.
   Assumes rtl/ design and header, the host model and checker in tb/. */
module flash_power_on_reset_state_tb_top;
    timeunit 1ns;
    timeprecision 100ps;
    localparam logic [19:0] PE_CYC = 20'h00032;
    logic       sys_clk, rst, sck, cs_n, si, so_o, so_oe, so_pin, out_req, tx_load;
    logic       op_v, rx_v, mode3, sel, stby, pe_rdy, want_rd, m;
    logic [7:0] tx_byte, opcode, rx_byte, rd, op;
    logic [7:0] exp_q[$], rx_q[$];
    int         errors, total_checks;
    assign so_pin = so_oe ? so_o : 1'bz;

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    flash_power_on_reset_state #(.PE_DELAY_CYCLES(PE_CYC)) dut (
        .sys_clk(sys_clk), .rst(rst), .spi_clk_pin(sck), .chip_select_n_pin(cs_n),
        .serial_in_pin(si), .serial_output_o(so_o), .serial_output_oe(so_oe),
        .output_request(out_req), .tx_byte(tx_byte), .tx_load(tx_load), .opcode(opcode),
        .opcode_valid(op_v), .rx_byte(rx_byte), .rx_valid(rx_v), .spi_mode3(mode3),
        .selected(sel), .standby(stby), .program_erase_ready(pe_rdy));
    spi_host_model host (.sys_clk(sys_clk), .so_pin(so_pin), .sck(sck), .cs_n(cs_n), .si(si));

    task chk_flag(input string what, input logic e, input logic g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %b seen %b", what, e, g);
        end
    endtask
    task chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task complete_run();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task wait_standby();
        int n;
        n = 0;
        while (stby !== 1'b1 && n < 50) begin
            @(posedge sys_clk);
            #1;
            n++;
        end
        chk_flag("standby", 1'b1, stby);
    endtask

    // ==========================================
    // core model: answers opcodes, checks every opcode and data byte
    always @(posedge sys_clk) begin
        if (op_v === 1'b1) begin
            chk_flag("opcode expected", 1'b1, exp_q.size() > 0);
            if (exp_q.size() > 0)
                chk_byte("opcode", exp_q.pop_front(), opcode);
            out_req <= #1 want_rd;
        end
        if (rx_v === 1'b1) begin
            chk_flag("rx byte expected", 1'b1, rx_q.size() > 0);
            if (rx_q.size() > 0)
                chk_byte("rx byte", rx_q.pop_front(), rx_byte);
        end
        if (tx_load === 1'b1)
            out_req <= #1 1'b0;
    end

    // ==========================================
    initial begin
        rst = 1'b1;
        out_req = 1'b0;
        tx_byte = 8'h00;
        want_rd = 1'b0;
        void'($urandom(68));
        repeat (6) @(posedge sys_clk);
        #1;
        chk_flag("mode3 in reset", 1'b1, mode3);
        chk_flag("so enable in reset", 1'b0, so_oe);
        chk_flag("standby in reset", 1'b0, stby);
        rst = 1'b0;
        wait_standby();
        chk_flag("mode3 after reset", 1'b1, mode3);
        chk_flag("pe ready early", 1'b0, pe_rdy);
        host.power_up_wait();
        chk_flag("pe ready", 1'b1, pe_rdy);
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            m = i[0];
            op = 8'($urandom);
            want_rd = (i >= 4);
            tx_byte = 8'($urandom);
            exp_q.push_back(op);
            if (want_rd)
                rx_q.push_back(~op);
            host.frame(m, op, want_rd, rd);
            chk_flag("spi mode", m, mode3);
            if (want_rd)
                chk_byte("read data", tx_byte, rd);
            chk_flag("so released", 1'b0, so_oe);
            chk_flag("standby after frame", 1'b1, stby);
        end
        $display("test frames done");
        host.idle_clocks(16);
        chk_flag("no frame on idle clocks", 1'b0, sel);
        rst = 1'b1;
        fork
            host.frame(1'b0, 8'h5A, 1'b0, rd);
            begin
                repeat (20) @(posedge sys_clk);
                #1;
                rst = 1'b0;
            end
        join
        wait_standby();
        chk_flag("select across reset ignored", 1'b1, mode3);
        $display("test select across reset done");
        complete_run();
    end

    initial begin
        #300000;
        errors++;
        $display("ERROR watchdog expected finish seen hang");
        complete_run();
    end
endmodule // flash_power_on_reset_state_tb_top

bind flash_power_on_reset_state flash_por_sva #(.PE_DELAY_CYCLES(PE_DELAY_CYCLES)) u_sva (
    .sys_clk(sys_clk), .rst(rst), .serial_output_oe(serial_output_oe),
    .output_request(output_request), .tx_load(tx_load), .opcode_valid(opcode_valid),
    .rx_valid(rx_valid), .spi_mode3(spi_mode3), .selected(selected), .standby(standby),
    .program_erase_ready(program_erase_ready));

// ===== tb/spi_host_model.sv
/* SPI host model: drives clock, select and data in, samples data out.
   Assumes the bench clock; SCK period is 16 sys_clk cycles (80 ns). */
`include "flash_por_regs.vh"
module spi_host_model (
    input  logic sys_clk,
    input  logic so_pin,
    output logic sck,
    output logic cs_n,
    output logic si
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        sck = 1'b1;
        cs_n = 1'b1;
        si = 1'b0;
    end

    task half();
        repeat (8) @(posedge sys_clk);
        #1;
    endtask

    // supply settle wait counted on our own clock
    task power_up_wait();
        repeat (`FPOR_VCC_TO_SELECT_CYC) @(posedge sys_clk);
        #1;
    endtask

    task shift(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            sck = 1'b0;
            si = tx[i];
            half();
            sck = 1'b1;
            rx[i] = so_pin;
            half();
        end
    endtask

    // opcode, then one read byte carrying ~op on data in when rd is set
    task frame(input logic m3, input logic [7:0] op, input logic rd, output logic [7:0] rx);
        logic [7:0] dummy;
        sck = m3;
        half();
        cs_n = 1'b0;
        half();
        shift(op, dummy);
        if (rd)
            shift(~op, rx);
        sck = m3;
        half();
        cs_n = 1'b1;
        si = ~si; // released line must not look held
        half();
    endtask

    // clock with select high: must be ignored
    task idle_clocks(input int n);
        repeat (n) begin
            sck = ~sck;
            half();
        end
    endtask
endmodule // spi_host_model
